// File: hw/amet_defines.svh
`ifndef AMET_DEFINES_SVH
`define AMET_DEFINES_SVH

// ****************************************************************
// Register offsets (byte addresses, 12-bit window)
// ****************************************************************
`define AMET_ADDR_W            12
`define AMET_ARCH_EVT3_OFS     12'h40C
`define AMET_AUX_EVT0_OFS      12'h480
`define AMET_AUX_EVT1_OFS      12'h484
`define AMET_CFG_OFS           12'hCE0
`define AMET_CTRL_OFS          12'hF00
`define AMET_STAT_OFS          12'hF04

// Event type blocks: address bits [11:6] select the group
`define AMET_ARCH_BLK          6'h10
`define AMET_AUX_BLK           6'h12

// ****************************************************************
// Event numbers and register indices
// ****************************************************************
`define AMET_ARCH3_IDX         4'h3
`define AMET_AUX0_IDX          4'h0
`define AMET_AUX1_IDX          4'h1
`define AMET_EVT_MEM_STALL     16'h1005
`define AMET_EVT_GEAR0         16'h0180
`define AMET_EVT_GEAR1         16'h0301

// ****************************************************************
// Group sizes and field positions
// ****************************************************************
`define AMET_ARCH_CNT_RST      4
`define AMET_AUX_CNT_RST       3
`define AMET_CNT_MAX           16
`define AMET_CFG_ARCH_LSB      0
`define AMET_CFG_AUX_LSB       8
`define AMET_CTRL_ERR_EN_BIT   0
`define AMET_STAT_RO_WR_BIT    0
`define AMET_STAT_RAZ_RD_BIT   1
`define AMET_CTRL_RST          1'h0
`define AMET_STAT_RST          2'h0
`define AMET_WORD_ZERO         32'h0000_0000

`endif

// File: hw/amet_pkg.sv
`default_nettype none

package amet_pkg;

    typedef logic [31:0] amet_word_t;
    typedef logic [15:0] amet_evt_t;

    typedef enum logic [2:0]
    {
        AMET_IDLE = 3'b001,
        AMET_LOOK = 3'b010,
        AMET_DONE = 3'b100
    } amet_state_e;

endpackage : amet_pkg

`default_nettype wire

// File: hw/amet_evt_rom.sv
`include "amet_defines.svh"
`default_nettype none

module amet_evt_rom
    import amet_pkg::*;
#(
    parameter int unsigned IDX_W = 4
)
(
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               lookup_en,
    input  wire logic               grp_aux,
    input  wire logic [IDX_W-1:0]   index,
    input  wire logic [7:0]         arch_count,
    input  wire logic [7:0]         aux_count,
    output var  amet_word_t         evt_word_ff,
    output var  logic               raz_ff
);

    if (IDX_W != 4)
    begin : g_bad_idx_w
        $error("amet_evt_rom: IDX_W must be 4");
    end

    // ************************************************************
    // Hard-wired event table
    // ************************************************************
    wire amet_evt_t  arch_evt;
    wire amet_evt_t  aux_evt;
    wire logic [7:0] idx_ext;
    wire logic       idx_impl;
    wire amet_word_t nxt_evt_word;

    assign arch_evt = (index == `AMET_ARCH3_IDX) ?
                      `AMET_EVT_MEM_STALL : 16'h0000;
    assign aux_evt  = (index == `AMET_AUX0_IDX) ? `AMET_EVT_GEAR0 :
                      (index == `AMET_AUX1_IDX) ? `AMET_EVT_GEAR1 :
                      16'h0000;

    assign idx_ext  = 8'(index);
    // Index checked against the live group size
    assign idx_impl = grp_aux ? (idx_ext < aux_count)
                              : (idx_ext < arch_count);

    // One table feeds every view, so they cannot disagree
    assign nxt_evt_word = idx_impl ?
                          {16'h0000, grp_aux ? aux_evt : arch_evt}
                          : `AMET_WORD_ZERO;

    // ************************************************************
    // Registered read port
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            evt_word_ff <= `AMET_WORD_ZERO;
            raz_ff      <= 1'b0;
        end
        else if (lookup_en)
        begin
            evt_word_ff <= nxt_evt_word;
            raz_ff      <= ~idx_impl;
        end
    end

endmodule : amet_evt_rom

`default_nettype wire

// File: hw/amet_regs.sv
// Summary of operation
// - Event type word carries the event number low, upper 16 bits zero.
// - Architected type register 3 reports memory stall cycles event.
// - Auxiliary type register 0 reports gear 0 threshold exceeded event.
// - Auxiliary type register 1 reports gear 1 threshold exceeded event.
// - Architected index at or above implemented count reads zero.
// - Auxiliary index at or above implemented count reads zero.
// - Architected count comes from the group configuration field.
// - Auxiliary count comes from the group configuration field.
// - External word equals the system register view, all 32 bits.
// - Event type registers are read-only; writes leave them unchanged, set status bit 0 and, if enabled, pslverr.
// - Upper bits reset to zero; event field has no defined reset.
// - Auxiliary group holds three counters; configuration reports three.
`include "amet_defines.svh"
`default_nettype none

module amet_regs
    import amet_pkg::*;
#(
    parameter int unsigned ARCH_CNT = `AMET_ARCH_CNT_RST,
    parameter int unsigned AUX_CNT  = `AMET_AUX_CNT_RST
)
(
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [`AMET_ADDR_W-1:0] paddr,
    input  wire logic [31:0]             pwdata,
    input  wire logic [3:0]              pstrb,
    output var  amet_word_t              prdata,
    output var  logic                    pready,
    output var  logic                    pslverr
);

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    if (ARCH_CNT > `AMET_CNT_MAX)
    begin : g_bad_arch_cnt
        $error("amet_regs: ARCH_CNT above 16");
    end
    if (AUX_CNT > `AMET_CNT_MAX)
    begin : g_bad_aux_cnt
        $error("amet_regs: AUX_CNT above 16");
    end

    // ************************************************************
    // Group configuration word
    // ************************************************************
    wire logic [7:0] arch_group_counter_count;
    wire logic [7:0] aux_group_counter_count;
    wire amet_word_t cfg_word;

    assign arch_group_counter_count = 8'(ARCH_CNT);
    assign aux_group_counter_count  = 8'(AUX_CNT);
    assign cfg_word = {16'h0000,
                       aux_group_counter_count,
                       arch_group_counter_count};

    // ************************************************************
    // State
    // ************************************************************
    amet_state_e state_ff;
    amet_state_e nxt_state;
    amet_word_t  prdata_ff;
    amet_word_t  nxt_prdata;
    logic        pready_ff;
    logic        nxt_pready;
    logic        pslverr_ff;
    logic        nxt_pslverr;
    logic        err_en_ff;
    logic        nxt_err_en;
    logic [1:0]  stat_ff;
    logic [1:0]  nxt_stat;

    amet_word_t  rom_word;
    logic        rom_raz;

    // ************************************************************
    // Address decode
    // ************************************************************
    wire logic       setup;
    wire logic       commit;
    wire logic       hit_arch;
    wire logic       hit_aux;
    wire logic       hit_evt;
    wire logic       hit_cfg;
    wire logic       hit_ctrl;
    wire logic       hit_stat;
    wire logic       hit_ro;
    wire logic [3:0] evt_index;
    wire logic [5:0] blk_sel;
    wire logic       ctrl_wr;

    // Upper address bits pick the register group
    assign blk_sel   = paddr[11:6];
    assign setup     = psel & ~penable;
    // Write takes effect only on the completing edge
    assign commit    = (state_ff == AMET_DONE) & psel & penable;
    assign hit_arch  = (blk_sel == `AMET_ARCH_BLK);
    assign hit_aux   = (blk_sel == `AMET_AUX_BLK);
    assign hit_evt   = hit_arch | hit_aux;
    assign hit_cfg   = (paddr == `AMET_CFG_OFS);
    assign hit_ctrl  = (paddr == `AMET_CTRL_OFS);
    assign hit_stat  = (paddr == `AMET_STAT_OFS);
    assign hit_ro    = hit_evt | hit_cfg;
    assign evt_index = paddr[5:2];
    // Only byte lane 0 carries control bits
    assign ctrl_wr   = commit & pwrite & hit_ctrl & pstrb[0];

    // ************************************************************
    // Event table lookup
    // ************************************************************
    // Lookup is registered, so the answer needs one extra cycle
    amet_evt_rom #(
        .IDX_W      (4)
    ) amet_evt_rom_inst (
        .pclk       (pclk),
        .presetn    (presetn),
        .lookup_en  (setup & hit_evt & (state_ff == AMET_IDLE)),
        .grp_aux    (hit_aux),
        .index      (evt_index),
        .arch_count (arch_group_counter_count),
        .aux_count  (aux_group_counter_count),
        .evt_word_ff(rom_word),
        .raz_ff     (rom_raz)
    );

    // ************************************************************
    // Read mux and responses
    // ************************************************************
    wire amet_word_t ctrl_word;
    wire amet_word_t stat_word;
    wire amet_word_t rd_word;
    wire logic       in_look;
    wire logic       ro_write;
    wire logic       raz_read;
    wire logic       stat_wr;
    wire logic [1:0] stat_clr;
    wire logic [1:0] stat_set;
    wire logic       look_rd;
    wire logic       look_wr;

    assign ctrl_word = {31'h0000_0000, err_en_ff};
    assign stat_word = {30'h0000_0000, stat_ff};
    assign rd_word   = hit_evt  ? rom_word  :
                       hit_cfg  ? cfg_word  :
                       hit_ctrl ? ctrl_word :
                       hit_stat ? stat_word :
                       `AMET_WORD_ZERO;
    assign in_look   = (state_ff == AMET_LOOK);
    assign look_rd   = in_look & ~pwrite;
    assign look_wr   = in_look & pwrite;
    assign ro_write  = commit & pwrite & hit_ro;
    assign raz_read  = in_look & ~pwrite & hit_evt & rom_raz;
    assign stat_wr   = commit & pwrite & hit_stat & pstrb[0];
    assign stat_clr  = stat_wr ? pwdata[1:0] : 2'h0;
    assign stat_set  = {raz_read, ro_write};

    // ************************************************************
    // Transfer sequencer
    // ************************************************************
    // Fixed three-cycle access; the table lookup takes one registered step
    always_comb
    begin
        nxt_state = AMET_IDLE;
        unique case (state_ff)
            AMET_IDLE: nxt_state = setup ? AMET_LOOK : AMET_IDLE;
            AMET_LOOK: nxt_state = AMET_DONE;
            AMET_DONE: nxt_state = AMET_IDLE;
            default:   nxt_state = AMET_IDLE;
        endcase
    end

    // ************************************************************
    // Response next values
    // ************************************************************
    always_comb
    begin
        nxt_pready = in_look;
    end

    // Quiet bus: read data is zero outside the answer cycle
    always_comb
    begin
        nxt_prdata = look_rd ? rd_word : `AMET_WORD_ZERO;
    end

    // Writes to read-only words are dropped, flagged if enabled
    always_comb
    begin
        nxt_pslverr = look_wr & hit_ro & err_en_ff;
    end

    // ************************************************************
    // Control and sticky status
    // ************************************************************
    always_comb
    begin
        nxt_err_en = err_en_ff;
        if (ctrl_wr)
            nxt_err_en = pwdata[`AMET_CTRL_ERR_EN_BIT];
    end

    // Set beats clear so an event in the clearing cycle survives
    always_comb
    begin
        nxt_stat = stat_set | (stat_ff & ~stat_clr);
    end

    // ************************************************************
    // Flops
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff <= AMET_IDLE;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // ************************************************************
    // Response flops
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_ff <= 1'b0;
        end
        else
        begin
            pready_ff <= nxt_pready;
        end
    end

    // Error answer only ever pairs with pready
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pslverr_ff <= 1'b0;
        end
        else
        begin
            pslverr_ff <= nxt_pslverr;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_ff <= `AMET_WORD_ZERO;
        end
        else
        begin
            prdata_ff <= nxt_prdata;
        end
    end

    // ************************************************************
    // Control and status flops
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            err_en_ff <= `AMET_CTRL_RST;
        end
        else
        begin
            err_en_ff <= nxt_err_en;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stat_ff <= `AMET_STAT_RST;
        end
        else
        begin
            stat_ff <= nxt_stat;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign prdata  = prdata_ff;
    assign pready  = pready_ff;
    assign pslverr = pslverr_ff;

endmodule : amet_regs

`default_nettype wire

// File: testbench/amet_regs_monitor.sv
`default_nettype none

module amet_regs_monitor
    import amet_pkg::*;
#(
    parameter int unsigned ARCH_CNT = 4,
    parameter int unsigned AUX_CNT  = 3
)
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire amet_word_t  prdata,
    input wire logic        pready,
    input wire logic        pslverr
);
    // ************************************************
    // Read and write answers, two edges after the setup edge
    // ************************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    wire ans_rd = pready && !pwrite;

    sequence setup_s(w, a);
        psel && !penable && pwrite == w && paddr == a;
    endsequence

    property rd_gives(a, d);
        setup_s(1'b0, a) |-> ##2 (pready && prdata == d);
    endproperty

    a_arch3_event:
        assert property (rd_gives(12'h40C, 32'h0000_1005))
        else $error("arch3 event word wrong");
    a_aux0_event:
        assert property (rd_gives(12'h480, 32'h0000_0180))
        else $error("aux0 event word wrong");
    a_aux1_event:
        assert property (rd_gives(12'h484, 32'h0000_0301))
        else $error("aux1 event word wrong");
    a_cfg_counts:
        assert property (rd_gives(12'hCE0, (AUX_CNT << 8) | ARCH_CNT))
        else $error("group config word wrong");
    a_aux_three:
        assert property (ans_rd && paddr == 12'hCE0 |-> prdata[15:8] == 8'h03)
        else $error("aux group size not three");
    a_upper_zero:
        assert property (ans_rd && paddr[11:8] == 4'h4 |-> !(|prdata[31:16]))
        else $error("event word upper half not zero");
    a_arch_raz:
        assert property (ans_rd && paddr[11:6] == 6'h10
            && paddr[5:2] >= ARCH_CNT |-> prdata == 32'h0)
        else $error("arch index beyond count not zero");
    a_aux_raz:
        assert property (ans_rd && paddr[11:6] == 6'h12
            && paddr[5:2] >= AUX_CNT |-> prdata == 32'h0)
        else $error("aux index beyond count not zero");
    a_ro_write:
        assert property (setup_s(1'b1, 12'h40C) |=> !pready [*1]
            ##1 (pready && prdata == 32'h0))
        else $error("write to event word misbehaved");
    a_err_write:
        assert property (pslverr |-> pready && pwrite && $past(psel))
        else $error("error flag outside a write answer");
endmodule : amet_regs_monitor

bind amet_regs amet_regs_monitor #(
    .ARCH_CNT(ARCH_CNT),
    .AUX_CNT (AUX_CNT)
) amet_regs_monitor_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr)
);

`default_nettype wire

// File: testbench/activity_monitor_event_types_tb.sv
`default_nettype none

module activity_monitor_event_types_tb
    import amet_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    amet_word_t  prdata, rd;
    int          fails = 0, cmp_count = 0, ctrl_m = 0, stat_m = 0, i;
    logic [11:0] i_list [4] = '{12'h40C, 12'h480, 12'h484, 12'hCE0};
    logic [3:0]  wr_strb = 4'hF;

    amet_regs #(.ARCH_CNT(4), .AUX_CNT(3)) amet_regs_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));

    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task results();
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : results

    task check(input string what, input amet_word_t seen, exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value %s exp %h seen %h", what, exp, seen);
        end
    endtask : check

    // ************************************************
    // Bus master; leaves the bus held for back-to-back
    // ************************************************
    task apb(input logic w, input logic [11:0] a, input amet_word_t d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= w ? wr_strb : 4'h0;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (n == 20)
        begin
            fails++;
            results();
        end
        rd = prdata;
        err = pslverr;
    endtask : apb

    function automatic amet_word_t model(input logic [11:0] a);
        case (a)
            12'h40C: return 32'h0000_1005;
            12'h480: return 32'h0000_0180;
            12'h484: return 32'h0000_0301;
            12'hCE0: return 32'h0000_0304;
            12'hF00: return ctrl_m;
            12'hF04: return stat_m;
            default: return 32'h0000_0000;
        endcase
    endfunction : model

    task rdc(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
        check("rdata", rd, model(a));
        check("rderr", {31'h0, err}, 32'h0);
        if ((a[11:6] == 6'h10 && a[5:2] >= 4) ||
            (a[11:6] == 6'h12 && a[5:2] >= 3))
            stat_m |= 2;
    endtask : rdc

    task wrc(input logic [11:0] a, input amet_word_t d);
        logic ro;
        ro = (a[11:8] == 4'h4 && !a[6]) || a == 12'hCE0;
        apb(1'b1, a, d);
        check("wrerr", {31'h0, err}, {31'h0, ro & ctrl_m[0]});
        if (ro)
            stat_m |= 1;
        if (a == 12'hF00 && wr_strb[0])
            ctrl_m = d[0];
        if (a == 12'hF04 && wr_strb[0])
            stat_m &= ~d[1:0];
    endtask : wrc

    initial
    begin
        void'($urandom(32'h277D));
        {presetn, psel, penable, pwrite} <= 4'h0;
        {paddr, pwdata, pstrb} <= 48'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc(12'hF00);
        rdc(12'hF04);
        rdc(12'hCE0);
        rdc(12'h40C);
        rdc(12'h480);
        rdc(12'h484);
        $display("test 1 done");
        for (i = 0; i < 16; i++)
        begin
            rdc(12'h400 + 12'(i * 4));
            rdc(12'h480 + 12'(i * 4));
        end
        rdc(12'hF04);
        $display("test 2 done");
        // Random data must never leak into a read-only word
        foreach (i_list[k])
        begin
            wrc(i_list[k], $urandom);
            rdc(i_list[k]);
        end
        wrc(12'hF00, 32'h1);
        wrc(12'h40C, $urandom);
        rdc(12'h40C);
        rdc(12'hF04);
        // Byte lane 0 off: control and status must not move
        wr_strb = {3'($urandom), 1'b0};
        wrc(12'hF00, 32'h0);
        wrc(12'hF04, 32'h3);
        wr_strb = 4'hF;
        rdc(12'hF00);
        rdc(12'hF04);
        wrc(12'hF04, 32'h3);
        rdc(12'hF04);
        wrc(12'h100, $urandom);
        rdc(12'h100);
        $display("test 3 done");
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        ctrl_m = 0;
        stat_m = 0;
        @(posedge pclk);
        rdc(12'h40C);
        rdc(12'hF04);
        psel <= 1'b0;
        $display("test 4 done");
        results();
    end
endmodule : activity_monitor_event_types_tb

`default_nettype wire
